// >>> src/current_dac_ctrl.sv
// register file and output control for the programmable current source
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// How it works
// - bus output enable comes from software bit, or event channel when event control set
// - two-bit range code selects step size 50, 100, 500 or 2000 nA
// - five-bit step field sets current linearly over 32 settings
// - enable turns source on; stable reported only after warm-up count
// - output routes only to bus 1 x or y halves, channels 0 to 31
// - default drives channel select as master; follow-only stops driving selection
// - selecting a channel raises request; granted bits report bus answer
// - in master mode a foreign driver sets clash status and x or y clash
// - clearing software output enable drops drive, listen and request
// - clash sets interrupt flag; enable gates it; write one clears it
// - min-transition while sourcing ties internal node to ground before enable
// - min-transition while sinking ties internal node to supply rail
// - output enable with min-transition suspends pre-charge until output enable clears
// - duty cycling on in sleep levels 2 and 3 unless disable bit set
// - event channel select bits 23:20 pick channel 0 to 11
// - software tuning field trims each current step
// - under event control switch follows event level, on-time sets charge
// - reading flag-clear returns flags and clears them when read-clear enabled
module current_dac_ctrl
    import current_dac_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [REG_AW-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic read_clear_en_i,
    input wire logic [EVENT_CHANNELS-1:0] event_ch_i,
    input wire logic [1:0] sleep_level_i,
    input wire logic x_half_granted_i,
    input wire logic y_half_granted_i,
    input wire logic x_half_busy_i,
    input wire logic y_half_busy_i,
    output logic source_on_o,
    output logic sink_mode_o,
    output logic power_io_o,
    output logic sleep_delay_o,
    output logic [1:0] range_select_o,
    output logic [4:0] step_select_o,
    output logic [7:0] tuning_o,
    output logic [15:0] step_size_na_o,
    output logic current_stable_o,
    output logic out_switch_o,
    output logic x_half_req_o,
    output logic y_half_req_o,
    output logic drive_select_o,
    output logic [4:0] bus_channel_o,
    output logic node_to_ground_o,
    output logic node_to_supply_o,
    output logic low_power_cycling_o,
    output logic irq_o
);

    typedef enum logic [1:0] {WARM_OFF, WARM_RUN, WARM_DONE} warm_e;

    // address compare against one register offset
    function automatic logic hit(input logic [REG_AW-1:0] a, input logic [7:0] off);
        hit = (a == off[REG_AW-1:0]);
    endfunction

    // step size in nA for a range code
    function automatic logic [15:0] step_size(input logic [1:0] rng);
        unique case (rng)
            2'h0: step_size = 16'(STEP_NA_R0);
            2'h1: step_size = 16'(STEP_NA_R1);
            2'h2: step_size = 16'(STEP_NA_R2);
            2'h3: step_size = 16'(STEP_NA_R3);
        endcase
    endfunction

    // software visible registers
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] prog_r, prog_nxt;
    logic [31:0] duty_r, duty_nxt;
    logic [1:0] ien_r, ien_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // warm-up sequencing state
    warm_e warm_r, warm_nxt;
    logic [WARM_W-1:0] warm_cnt_r, warm_cnt_nxt;
    logic stable_r, stable_nxt;

    // analog bus handshake state
    logic [1:0] req_r, req_nxt;
    logic [1:0] clash_r, clash_nxt;
    logic [1:0] granted_r, granted_nxt;
    logic out_sw_r, out_sw_nxt;
    logic [1:0] xy_req_r, xy_req_nxt;
    logic drv_sel_r, drv_sel_nxt;

    // interrupt state
    logic [1:0] if_r, if_nxt;
    logic irq_r, irq_nxt;

    // output node conditioning and duty cycling
    logic gnd_r, gnd_nxt;
    logic sup_r, sup_nxt;
    logic cyc_r, cyc_nxt;

    logic [7:0] chsel;
    logic chan_valid;
    logic out_en;
    logic ev_level;
    logic [3:0] ev_sel;
    logic clash_now;

    always_comb begin
        chsel = ctrl_r[CTRL_CHSEL_MSB:CTRL_CHSEL_LSB];
        chan_valid = (chsel[7:5] == CHSEL_BUS1_TOP);
        ev_sel = ctrl_r[CTRL_EVSEL_MSB:CTRL_EVSEL_LSB];
        ev_level = (ev_sel <= EVENT_CH_MAX) ? event_ch_i[ev_sel] : 1'b0;
        out_en = ctrl_r[CTRL_EVCTL_BIT] ? ev_level : ctrl_r[CTRL_OUTEN_BIT];
    end

    // register writes and reads
    always_comb begin
        ctrl_nxt = ctrl_r;
        prog_nxt = prog_r;
        duty_nxt = duty_r;
        ien_nxt = ien_r;
        rdata_nxt = 32'h0000_0000;
        if (reg_wr_i) begin
            if (hit(reg_addr_i, OUTPUT_CONTROL_OFF)) begin
                ctrl_nxt = reg_wdata_i & CTRL_MASK;
            end
            if (hit(reg_addr_i, CURRENT_PROGRAM_OFF)) begin
                prog_nxt = reg_wdata_i & PROG_MASK;
            end
            if (hit(reg_addr_i, DUTY_CYCLE_CONFIG_OFF)) begin
                duty_nxt = reg_wdata_i & DUTY_MASK;
            end
            if (hit(reg_addr_i, INTERRUPT_ENABLE_OFF)) begin
                ien_nxt = reg_wdata_i[1:0];
            end
        end
        if (reg_rd_i) begin
            unique case (1'b1)
                hit(reg_addr_i, OUTPUT_CONTROL_OFF): begin
                    rdata_nxt = ctrl_r;
                end
                hit(reg_addr_i, CURRENT_PROGRAM_OFF): begin
                    rdata_nxt = prog_r;
                end
                hit(reg_addr_i, DUTY_CYCLE_CONFIG_OFF): begin
                    rdata_nxt = duty_r;
                end
                hit(reg_addr_i, STATUS_FLAGS_OFF): begin
                    rdata_nxt = {30'h0, |clash_r, 1'b0};
                end
                hit(reg_addr_i, INTERRUPT_FLAGS_OFF): begin
                    rdata_nxt = {30'h0, if_r};
                end
                hit(reg_addr_i, INTERRUPT_FLAG_CLEAR_OFF): begin
                    rdata_nxt = {30'h0, if_r};
                end
                hit(reg_addr_i, INTERRUPT_ENABLE_OFF): begin
                    rdata_nxt = {30'h0, ien_r};
                end
                hit(reg_addr_i, BUS_REQUEST_STATUS_OFF): begin
                    rdata_nxt = {28'h0, granted_r, 2'h0};
                end
                hit(reg_addr_i, BUS_CONFLICT_STATUS_OFF): begin
                    rdata_nxt = {28'h0, clash_r, 2'h0};
                end
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // warm-up sequencing
    always_comb begin
        warm_nxt = warm_r;
        warm_cnt_nxt = warm_cnt_r;
        unique case (warm_r)
            WARM_OFF: begin
                warm_cnt_nxt = '0;
                if (ctrl_r[CTRL_EN_BIT]) begin
                    warm_nxt = WARM_RUN;
                end
            end
            WARM_RUN: begin
                warm_cnt_nxt = warm_cnt_r + WARM_W'(1);
                if (warm_cnt_r == WARM_W'(WARMUP_CYCLES - 1)) begin
                    warm_nxt = WARM_DONE;
                end
            end
            WARM_DONE: begin
                warm_cnt_nxt = '0;
            end
            // the fourth code of the state word is unused
            default: begin
                warm_nxt = WARM_OFF;
                warm_cnt_nxt = '0;
            end
        endcase
        // disabling stops warm-up; reprogramming the current restarts settling
        if (!ctrl_r[CTRL_EN_BIT]) begin
            warm_nxt = WARM_OFF;
        end else if (reg_wr_i && hit(reg_addr_i, CURRENT_PROGRAM_OFF)) begin
            warm_nxt = WARM_RUN;
            warm_cnt_nxt = '0;
        end
        // stable is registered beside the state so the output comes from a flop
        stable_nxt = (warm_nxt == WARM_DONE);
    end

    // bus request, grant and clash tracking
    always_comb begin
        req_nxt = 2'h0;
        if (out_en && chan_valid) begin
            req_nxt = chsel[0] ? 2'b10 : 2'b01;
        end
        xy_req_nxt = req_nxt;
        drv_sel_nxt = (|req_nxt) && !ctrl_r[CTRL_FOLLOW_BIT];
        granted_nxt = req_r & {y_half_granted_i, x_half_granted_i};
        clash_nxt = ctrl_r[CTRL_FOLLOW_BIT] ? 2'h0 :
            (req_r & {y_half_busy_i, x_half_busy_i});
        out_sw_nxt = |req_nxt;
        clash_now = |clash_r;
    end

    // interrupt flags; hardware set wins over clear
    always_comb begin
        if_nxt = if_r;
        if (reg_wr_i && hit(reg_addr_i, INTERRUPT_FLAG_CLEAR_OFF)) begin
            if_nxt = if_nxt & ~reg_wdata_i[1:0];
        end
        if (reg_rd_i && read_clear_en_i && hit(reg_addr_i, INTERRUPT_FLAG_CLEAR_OFF)) begin
            if_nxt = 2'h0;
        end
        if (reg_wr_i && hit(reg_addr_i, INTERRUPT_FLAG_SET_OFF)) begin
            if_nxt = if_nxt | reg_wdata_i[1:0];
        end
        if (clash_now) begin
            if_nxt[IF_CLASH_BIT] = 1'b1;
        end
        if (warm_r == WARM_RUN && warm_nxt == WARM_DONE) begin
            if_nxt[IF_STABLE_BIT] = 1'b1;
        end
        irq_nxt = |(if_nxt & ien_nxt);
    end

    // pre-charge, duty cycling
    always_comb begin
        gnd_nxt = 1'b0;
        sup_nxt = 1'b0;
        if (ctrl_r[CTRL_MINTRANS_BIT] && !out_en) begin
            if (ctrl_r[CTRL_SINK_BIT]) begin
                sup_nxt = 1'b1;
            end else begin
                gnd_nxt = 1'b1;
            end
        end
        // software keeps this off while sinking
        cyc_nxt = (sleep_level_i >= SLEEP_L2) && !duty_r[DUTY_OFF_BIT];
    end

    // software registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
            prog_r <= PROG_RESET;
            duty_r <= 32'h0000_0000;
            ien_r <= 2'h0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            prog_r <= prog_nxt;
            duty_r <= duty_nxt;
            ien_r <= ien_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // warm-up state
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            warm_r <= WARM_OFF;
            warm_cnt_r <= '0;
            stable_r <= 1'b0;
        end else begin
            warm_r <= warm_nxt;
            warm_cnt_r <= warm_cnt_nxt;
            stable_r <= stable_nxt;
        end
    end

    // analog bus handshake state
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            req_r <= 2'h0;
            clash_r <= 2'h0;
            granted_r <= 2'h0;
            out_sw_r <= 1'b0;
            xy_req_r <= 2'h0;
            drv_sel_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
            clash_r <= clash_nxt;
            granted_r <= granted_nxt;
            out_sw_r <= out_sw_nxt;
            xy_req_r <= xy_req_nxt;
            drv_sel_r <= drv_sel_nxt;
        end
    end

    // interrupt state
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            if_r <= IF_RESET;
            irq_r <= 1'b0;
        end else begin
            if_r <= if_nxt;
            irq_r <= irq_nxt;
        end
    end

    // output node conditioning and duty cycling
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            gnd_r <= 1'b0;
            sup_r <= 1'b0;
            cyc_r <= 1'b0;
        end else begin
            gnd_r <= gnd_nxt;
            sup_r <= sup_nxt;
            cyc_r <= cyc_nxt;
        end
    end

    // configuration outputs come directly from the register flops
    assign reg_rdata_o = rdata_r;
    assign source_on_o = ctrl_r[CTRL_EN_BIT];
    assign sink_mode_o = ctrl_r[CTRL_SINK_BIT];
    assign power_io_o = ctrl_r[CTRL_PWRSEL_BIT];
    assign sleep_delay_o = ctrl_r[CTRL_SLEEPDLY_BIT];
    assign range_select_o = prog_r[PROG_RANGE_MSB:PROG_RANGE_LSB];
    assign step_select_o = prog_r[PROG_STEP_MSB:PROG_STEP_LSB];
    assign tuning_o = prog_r[PROG_TUNE_MSB:PROG_TUNE_LSB];
    assign current_stable_o = stable_r;

    // bus handshake, node conditioning and interrupt
    assign out_switch_o = out_sw_r;
    assign x_half_req_o = xy_req_r[0];
    assign y_half_req_o = xy_req_r[1];
    assign drive_select_o = drv_sel_r;
    assign bus_channel_o = ctrl_r[CTRL_CHSEL_LSB+4:CTRL_CHSEL_LSB];
    assign node_to_ground_o = gnd_r;
    assign node_to_supply_o = sup_r;
    assign low_power_cycling_o = cyc_r;
    assign irq_o = irq_r;

    // step size lookup registered alongside the range code
    logic [15:0] step_na_r;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            step_na_r <= 16'(STEP_NA_R0);
        end else begin
            step_na_r <= step_size(prog_nxt[PROG_RANGE_MSB:PROG_RANGE_LSB]);
        end
    end
    assign step_size_na_o = step_na_r;

endmodule // current_dac_ctrl

// >>> shared/current_dac_pkg.sv
// constants for the current dac output control block
package current_dac_pkg;
    localparam int REG_AW = 8;
    localparam logic [7:0] OUTPUT_CONTROL_OFF = 8'h00;
    localparam logic [7:0] CURRENT_PROGRAM_OFF = 8'h04;
    localparam logic [7:0] DUTY_CYCLE_CONFIG_OFF = 8'h0C;
    localparam logic [7:0] STATUS_FLAGS_OFF = 8'h18;
    localparam logic [7:0] INTERRUPT_FLAGS_OFF = 8'h20;
    localparam logic [7:0] INTERRUPT_FLAG_SET_OFF = 8'h24;
    localparam logic [7:0] INTERRUPT_FLAG_CLEAR_OFF = 8'h28;
    localparam logic [7:0] INTERRUPT_ENABLE_OFF = 8'h2C;
    localparam logic [7:0] BUS_REQUEST_STATUS_OFF = 8'h34;
    localparam logic [7:0] BUS_CONFLICT_STATUS_OFF = 8'h38;
    // output_control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SINK_BIT = 1;
    localparam int CTRL_MINTRANS_BIT = 2;
    localparam int CTRL_OUTEN_BIT = 3;
    localparam int CTRL_CHSEL_LSB = 4;
    localparam int CTRL_CHSEL_MSB = 11;
    localparam int CTRL_PWRSEL_BIT = 12;
    localparam int CTRL_SLEEPDLY_BIT = 13;
    localparam int CTRL_FOLLOW_BIT = 14;
    localparam int CTRL_EVCTL_BIT = 16;
    localparam int CTRL_EVSEL_LSB = 20;
    localparam int CTRL_EVSEL_MSB = 23;
    localparam logic [31:0] CTRL_MASK = 32'h00F1_7FFF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // current_program fields
    localparam int PROG_RANGE_LSB = 0;
    localparam int PROG_RANGE_MSB = 1;
    localparam int PROG_STEP_LSB = 8;
    localparam int PROG_STEP_MSB = 12;
    localparam int PROG_TUNE_LSB = 16;
    localparam int PROG_TUNE_MSB = 23;
    localparam logic [31:0] PROG_MASK = 32'h00FF_1F03;
    localparam logic [31:0] PROG_RESET = 32'h009B_0000;
    localparam int DUTY_OFF_BIT = 1;
    localparam logic [31:0] DUTY_MASK = 32'h0000_0002;
    // interrupt flags
    localparam int IF_STABLE_BIT = 0;
    localparam int IF_CLASH_BIT = 1;
    localparam logic [1:0] IF_RESET = 2'h0;
    // channel select: bus 1 occupies codes 0x20..0x3F, bit0 picks y half
    localparam logic [2:0] CHSEL_BUS1_TOP = 3'h1;
    localparam int EVENT_CHANNELS = 12;
    localparam logic [3:0] EVENT_CH_MAX = 4'hB;
    // step sizes in nA per range code
    localparam int STEP_NA_R0 = 50;
    localparam int STEP_NA_R1 = 100;
    localparam int STEP_NA_R2 = 500;
    localparam int STEP_NA_R3 = 2000;
    localparam int STEP_COUNT = 32;
    // warm-up interval
    localparam int CLK_MHZ = 100;
    localparam int WARMUP_US = 5;
    localparam int WARMUP_CYCLES = WARMUP_US * CLK_MHZ;
    localparam int WARM_W = 10;
    // sleep level encoding
    localparam logic [1:0] SLEEP_L2 = 2'h2;
endpackage

// >>> verif/current_dac_ctrl_asserts.sv
// concurrent checks on the current dac control ports
`timescale 1ns/1ps
module current_dac_ctrl_asserts
    import current_dac_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [1:0] sleep_level_i,
    input wire logic source_on_o,
    input wire logic sink_mode_o,
    input wire logic [1:0] range_select_o,
    input wire logic [15:0] step_size_na_o,
    input wire logic current_stable_o,
    input wire logic out_switch_o,
    input wire logic x_half_req_o,
    input wire logic y_half_req_o,
    input wire logic [4:0] bus_channel_o,
    input wire logic node_to_ground_o,
    input wire logic node_to_supply_o,
    input wire logic low_power_cycling_o
);
    localparam int WARM_MIN = WARMUP_CYCLES - 2;
    logic [10:0] on_cnt_r;
    logic [10:0] on_cnt_nxt;
    // cycles the source has been on, saturating
    always_comb begin
        on_cnt_nxt = on_cnt_r;
        if (!source_on_o) begin
            on_cnt_nxt = 11'h000;
        end else if (on_cnt_r != 11'h7FF) begin
            on_cnt_nxt = on_cnt_r + 11'h001;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            on_cnt_r <= 11'h000;
        end else begin
            on_cnt_r <= on_cnt_nxt;
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    sequence range_held;
        $stable(range_select_o) [*2];
    endsequence
    sequence awake_low;
        (sleep_level_i < 2'h2) [*3];
    endsequence
    a_step_matches_range: assert property (range_held |-> step_size_na_o ==
        (range_select_o == 2'h0 ? 16'h0032 : range_select_o == 2'h1 ? 16'h0064 :
        range_select_o == 2'h2 ? 16'h01F4 : 16'h07D0)) else $error("step size wrong");
    a_stable_after_warm: assert property ($rose(current_stable_o) |-> on_cnt_r >= WARM_MIN)
        else $error("stable before warm-up");
    a_req_needs_switch: assert property ((x_half_req_o || y_half_req_o) |-> out_switch_o)
        else $error("request without output enable");
    a_half_by_channel: assert property (y_half_req_o |-> $past(bus_channel_o[0]))
        else $error("y half request on x channel");
    a_ground_sourcing: assert property (node_to_ground_o |-> !$past(sink_mode_o))
        else $error("ground tie while sinking");
    a_supply_sinking: assert property (node_to_supply_o |-> $past(sink_mode_o))
        else $error("supply tie while sourcing");
    a_precharge_halted: assert property ((node_to_ground_o || node_to_supply_o) |->
        !out_switch_o) else $error("precharge with output on");
    a_cycling_needs_sleep: assert property (awake_low |-> !low_power_cycling_o)
        else $error("duty cycling while awake");
endmodule // current_dac_ctrl_asserts
bind current_dac_ctrl current_dac_ctrl_asserts current_dac_ctrl_asserts_i (.clk_sys_i, .rst_i,
    .sleep_level_i, .source_on_o, .sink_mode_o, .range_select_o, .step_size_na_o,
    .current_stable_o, .out_switch_o, .x_half_req_o, .y_half_req_o, .bus_channel_o,
    .node_to_ground_o, .node_to_supply_o, .low_power_cycling_o);

// >>> verif/analog_bus_model.sv
// analog bus model: grants a requested half unless a foreign driver holds it
`timescale 1ns/1ps
module analog_bus_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic x_req_i,
    input wire logic y_req_i,
    input wire logic foreign_i,
    output logic x_granted_o,
    output logic y_granted_o,
    output logic x_busy_o,
    output logic y_busy_o
);
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            x_granted_o <= 1'b0;
            y_granted_o <= 1'b0;
            x_busy_o <= 1'b0;
            y_busy_o <= 1'b0;
        end else begin
            x_granted_o <= x_req_i && !foreign_i;
            y_granted_o <= y_req_i && !foreign_i;
            x_busy_o <= x_req_i && foreign_i;
            y_busy_o <= y_req_i && foreign_i;
        end
    end
endmodule // analog_bus_model

// >>> verif/current_dac_ctrl_tb_top.sv
// self-checking bench for the current dac control block
`timescale 1ns/1ps
module current_dac_ctrl_tb_top import current_dac_pkg::*;;
    logic clk_sys_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, read_clear_en_i = 0, clash = 0;
    logic [7:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, d;
    logic [11:0] event_ch_i = 0;
    logic [1:0] sleep_level_i = 0, range_select_o;
    logic x_half_granted_i, y_half_granted_i, x_half_busy_i, y_half_busy_i, source_on_o;
    logic sink_mode_o, power_io_o, sleep_delay_o, current_stable_o, out_switch_o, irq_o;
    logic x_half_req_o, y_half_req_o, drive_select_o, node_to_ground_o, node_to_supply_o;
    logic low_power_cycling_o;
    logic [4:0] step_select_o, bus_channel_o;
    logic [7:0] tuning_o;
    logic [15:0] step_size_na_o;
    int bad_count = 0, checks_done = 0, cyc = 0, n, r, s, t, if_m;
    int steps[4] = '{50, 100, 500, 2000};
    initial forever #5 clk_sys_i = ~clk_sys_i;
    current_dac_ctrl current_dac_ctrl_i (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .read_clear_en_i, .event_ch_i, .sleep_level_i,
        .x_half_granted_i, .y_half_granted_i, .x_half_busy_i, .y_half_busy_i, .source_on_o,
        .sink_mode_o, .power_io_o, .sleep_delay_o, .range_select_o, .step_select_o, .tuning_o,
        .step_size_na_o, .current_stable_o, .out_switch_o, .x_half_req_o, .y_half_req_o,
        .drive_select_o, .bus_channel_o, .node_to_ground_o, .node_to_supply_o,
        .low_power_cycling_o, .irq_o);
    analog_bus_model analog_bus_model_i (.clk_sys_i, .rst_i, .x_req_i(x_half_req_o),
        .y_req_i(y_half_req_o), .foreign_i(clash), .x_granted_o(x_half_granted_i),
        .y_granted_o(y_half_granted_i), .x_busy_o(x_half_busy_i), .y_busy_o(y_half_busy_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        n = $urandom(22);
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rreg(CURRENT_PROGRAM_OFF, d);
        chk(d, PROG_RESET);
        rreg(8'h40, d);
        chk(d, 0);
        chk(step_size_na_o, steps[0]);
        $display("test reset done");
        for (r = 0; r < 4; r++) begin
            s = $urandom % STEP_COUNT;
            t = $urandom % 256;
            wreg(CURRENT_PROGRAM_OFF, (t << 16) | (s << 8) | r);
            idle(3);
            chk(range_select_o, r);
            chk(step_select_o, s);
            chk(tuning_o, t);
            chk(step_size_na_o, steps[r]);
        end
        $display("test program done");
        wreg(OUTPUT_CONTROL_OFF, 32'h0000_0001);
        n = 0;
        while (current_stable_o !== 1'b1 && n < 2000) begin
            idle(1);
            n++;
        end
        chk(n >= WARMUP_CYCLES - 3 && n <= WARMUP_CYCLES + 3, 1);
        if_m = 1;
        rreg(INTERRUPT_FLAGS_OFF, d);
        chk(d, if_m);
        wreg(INTERRUPT_FLAG_CLEAR_OFF, 32'h0000_0001);
        $display("test warm-up done");
        wreg(INTERRUPT_ENABLE_OFF, 32'h0000_0002);
        clash <= 1'b1;
        wreg(OUTPUT_CONTROL_OFF, 32'h0000_0219);
        idle(6);
        chk({x_half_req_o, y_half_req_o, bus_channel_o}, 7'h21);
        chk(drive_select_o, 1);
        chk(irq_o, 1);
        if_m = 2;
        rreg(INTERRUPT_FLAGS_OFF, d);
        chk(d, if_m);
        rreg(STATUS_FLAGS_OFF, d);
        chk(d, 32'h0000_0002);
        rreg(BUS_CONFLICT_STATUS_OFF, d);
        chk(d, 32'h0000_0008);
        clash <= 1'b0;
        idle(3);
        wreg(INTERRUPT_FLAG_CLEAR_OFF, 32'h0000_0002);
        idle(2);
        chk(irq_o, 0);
        rreg(BUS_REQUEST_STATUS_OFF, d);
        chk(d, 32'h0000_0008);
        // the foreign driver appears only once follow-only has taken effect
        wreg(OUTPUT_CONTROL_OFF, 32'h0000_4219);
        clash <= 1'b1;
        idle(6);
        chk({drive_select_o, irq_o}, 0);
        wreg(OUTPUT_CONTROL_OFF, 32'h0000_0001);
        idle(4);
        chk({x_half_req_o, y_half_req_o, out_switch_o}, 0);
        clash <= 1'b0;
        $display("test bus done");
        for (r = 0; r < 16; r++) begin
            wreg(OUTPUT_CONTROL_OFF, (r << 20) | 32'h0001_0209);
            for (s = 0; s < 2; s++) begin
                @(posedge clk_sys_i) event_ch_i <= 12'($urandom);
                idle(4);
                chk(out_switch_o, r < EVENT_CHANNELS ? event_ch_i[r % 12] : 1'b0);
            end
        end
        $display("test event done");
        wreg(OUTPUT_CONTROL_OFF, 32'h0000_0005);
        idle(3);
        chk({node_to_ground_o, node_to_supply_o}, 2'h2);
        wreg(DUTY_CYCLE_CONFIG_OFF, 32'h0000_0002);
        wreg(OUTPUT_CONTROL_OFF, 32'h0000_0007);
        idle(3);
        chk({node_to_ground_o, node_to_supply_o}, 2'h1);
        wreg(OUTPUT_CONTROL_OFF, 32'h0000_020F);
        idle(3);
        chk({node_to_ground_o, node_to_supply_o, out_switch_o}, 3'h1);
        wreg(OUTPUT_CONTROL_OFF, 32'h0000_0207);
        idle(4);
        chk({node_to_ground_o, node_to_supply_o, out_switch_o}, 3'h2);
        wreg(OUTPUT_CONTROL_OFF, 32'h0000_3001);
        rreg(OUTPUT_CONTROL_OFF, d);
        chk(d, 32'h0000_3001);
        chk({power_io_o, sleep_delay_o, source_on_o, sink_mode_o}, 4'hE);
        $display("test precharge done");
        chk(current_stable_o, 1);
        for (r = 0; r < 8; r++) begin
            wreg(DUTY_CYCLE_CONFIG_OFF, (r & 4) >> 1);
            @(posedge clk_sys_i) sleep_level_i <= 2'(r);
            idle(4);
            chk(low_power_cycling_o, (r % 4) >= 2 && r < 4);
        end
        $display("test duty done");
        @(posedge clk_sys_i) read_clear_en_i <= 1'b1;
        wreg(INTERRUPT_FLAG_SET_OFF, 32'h0000_0003);
        if_m = 3;
        rreg(INTERRUPT_FLAG_CLEAR_OFF, d);
        chk(d, if_m);
        if_m = 0;
        rreg(INTERRUPT_FLAGS_OFF, d);
        chk(d, if_m);
        $display("test read-clear done");
        tally_and_finish();
    end
endmodule // current_dac_ctrl_tb_top
